// ---- verilog/bsx_core.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// RL1 - Clear-bit words (01 00bb bfff ffff) clear one file bit in one cycle without touching flags.
// RL2 - Set-bit words (01 01bb bfff ffff) set one file bit in one cycle without touching flags.
// RL3 - Test-skip-if-clear words (01 10bb bfff ffff) skip the next instruction when the bit is zero.
// RL4 - A taken skip turns the next fetched instruction into a no-operation, so it costs two cycles.
// RL5 - Bit words take a 7-bit file address and a 3-bit bit position from their fields.
// RL6 - Increment-skip-if-zero (00 1111 dfff ffff) adds one modulo 256 and keeps all flags.
// RL7 - Its result goes to the working register for destination 0 and to the file for 1.
// RL8 - A zero result skips the next instruction by the same discard mechanism.
// RL9 - OR of working and file register (00 0100 dfff ffff) writes the destination and updates zero.
// RL10 - Wake-up by interrupt with global enable set loads the program counter with 0004h.
// RL11 - Every wake-up comes with an interrupt flag set that names its cause.
// RL12 - Wake-up by comparator change sets bit 6 of the peripheral flag register; others leave it.
// RL13 - A brown-out reset clears bit 0 of the power control register; master clear leaves it, power-on reset clears the whole register.
// RL14 - Unimplemented register bits always read zero.
// RL15 - Power-on reset starts at address zero with the power-on flag cleared.
// RL16 - Each instruction is one 14-bit word whose top two bits pick the class first.
module bsx_core (
  // Clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Pins
  input  wire logic        extIntPin,
  input  wire logic        cmpOutPin,
  input  wire logic        masterResetPin,
  input  wire logic        brownOutPin,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Interrupt and state
  output logic             irq,
  output logic             sleeping_ff
);

  // ============================================================
  // Declarations
  logic [7:0]  fileMem [0:127];
  logic [7:0]  awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  logic        awHave_ff;
  logic        wHave_ff;
  logic [13:0] lastInstr_ff;
  logic [7:0]  work_ff;
  logic        zFlag_ff;
  logic        skipPend_ff;
  logic [12:0] pc_ff;
  logic [6:0]  fileAddr_ff;
  logic [7:0]  intCtrl_ff;
  logic [7:0]  pFlag1_ff;
  logic [7:0]  pEnable1_ff;
  logic [7:0]  pwrCtrl_ff;
  logic [4:0]  irqStat_ff;
  logic [4:0]  irqMask_ff;
  logic [15:0] instrCount_ff;
  logic [3:0]  pinsPrev_ff;
  logic [4:0]  nxt_irqStat;
  logic [3:0]  pinsSync;
  logic        wrAct;
  logic        instrWr;
  logic        execGo;
  logic        discard;
  logic        extRise;
  logic        cmpChange;
  logic        mclrRise;
  logic        borRise;
  logic        softReset;
  logic        wakeCond;
  logic        legal;
  logic [7:0]  result;
  logic        wrWork;
  logic        wrFile;
  logic        skip;
  logic        zUpdate;
  logic        zValue;
  logic [31:0] wMerged;
  logic [31:0] wMask;
  logic [31:0] readVal;
  logic        readHit;

  function automatic logic [31:0] strbMask(input logic [3:0] strb);
    strbMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  function automatic logic isReg(input logic [7:0] addr, input logic [7:0] reg_addr);
    isReg = ({addr[7:2], 2'b00} == reg_addr);
  endfunction

  // ============================================================
  // Pin synchronisers and edges
  bsx_pin_sync #(
    .WIDTH (4)
  ) u_pins (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .ce        (ce),
    .pinIn     ({brownOutPin, masterResetPin, cmpOutPin, extIntPin}),
    .stableOut (pinsSync)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pinsPrev_ff <= 4'h0;
    end else if (ce) begin
      pinsPrev_ff <= pinsSync;
    end
  end

  assign extRise   = pinsSync[0] & ~pinsPrev_ff[0];
  assign cmpChange = pinsSync[1] ^ pinsPrev_ff[1];
  assign mclrRise  = pinsSync[2] & ~pinsPrev_ff[2];
  assign borRise   = pinsSync[3] & ~pinsPrev_ff[3];
  assign softReset = mclrRise | borRise;

  // ============================================================
  // Execution datapath
  bsx_exec_unit u_exec (
    .instrWord (wData_ff[13:0]),
    .fileVal   (fileMem[wData_ff[6:0]]),
    .workVal   (work_ff),
    .legal     (legal),
    .result    (result),
    .wrWork    (wrWork),
    .wrFile    (wrFile),
    .skip      (skip),
    .zUpdate   (zUpdate),
    .zValue    (zValue)
  );

  assign wrAct    = awHave_ff & wHave_ff & ~s_axi_bvalid;
  assign wMask    = strbMask(wStrb_ff);
  assign instrWr  = wrAct & isReg(awAddr_ff, bsx_pkg::INSTR_ADDR) & ~sleeping_ff & ~softReset;
  // RL4 discard the prefetched word
  assign discard  = instrWr & skipPend_ff;
  assign execGo   = instrWr & ~skipPend_ff;
  // RL11 wake needs a set, enabled flag
  assign wakeCond = sleeping_ff & ((intCtrl_ff[bsx_pkg::INTF_POS] & intCtrl_ff[bsx_pkg::INTE_POS])
                  | (pFlag1_ff[bsx_pkg::CMPF_POS] & pEnable1_ff[bsx_pkg::CMPF_POS] & intCtrl_ff[bsx_pkg::PEIE_POS]));

  always_ff @(posedge sys_clk) begin
    if (ce) begin
      if (execGo && wrFile) begin
        fileMem[wData_ff[6:0]] <= result;
      end else if (wrAct && wStrb_ff[0] && isReg(awAddr_ff, bsx_pkg::FDATA_ADDR)) begin
        fileMem[fileAddr_ff] <= wData_ff[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      work_ff      <= bsx_pkg::REG8_RESET;
      zFlag_ff     <= 1'b0;
      lastInstr_ff <= bsx_pkg::NOP_WORD;
    end else if (ce) begin
      if (execGo && wrWork) begin
        work_ff <= result;
      end else if (wrAct && isReg(awAddr_ff, bsx_pkg::WORK_ADDR)) begin
        work_ff <= wMerged[7:0];
      end
      if (execGo && zUpdate) begin
        zFlag_ff <= zValue;
      end
      if (instrWr) begin
        lastInstr_ff <= wData_ff[13:0];
      end
    end
  end

  // RL15 start at zero after reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc_ff         <= bsx_pkg::PC_RESET;
      skipPend_ff   <= 1'b0;
      sleeping_ff   <= 1'b0;
      instrCount_ff <= 16'h0000;
    end else if (ce) begin
      if (softReset) begin
        pc_ff       <= bsx_pkg::PC_RESET;
        skipPend_ff <= 1'b0;
        sleeping_ff <= 1'b0;
      end else if (wakeCond) begin
        sleeping_ff <= 1'b0;
        // RL10 vector on enabled wake
        pc_ff <= intCtrl_ff[bsx_pkg::GLBEN_POS] ? bsx_pkg::INT_VECTOR : pc_ff + 13'h0001;
      end else if (instrWr) begin
        pc_ff         <= pc_ff + 13'h0001;
        skipPend_ff   <= execGo & skip;
        instrCount_ff <= instrCount_ff + 16'h0001;
      end else if (wrAct && wStrb_ff[0] && wData_ff[0] && isReg(awAddr_ff, bsx_pkg::CTRL_ADDR)) begin
        sleeping_ff <= 1'b1;
      end
    end
  end

  // ============================================================
  // Flag and control registers
  assign wMerged = wData_ff & wMask;

  // Hardware set wins over a software write in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      intCtrl_ff  <= bsx_pkg::REG8_RESET;
      pFlag1_ff   <= bsx_pkg::REG8_RESET;
      pEnable1_ff <= bsx_pkg::REG8_RESET;
      fileAddr_ff <= 7'h00;
    end else if (ce) begin
      if (softReset) begin
        intCtrl_ff  <= bsx_pkg::REG8_RESET;
        pFlag1_ff   <= bsx_pkg::REG8_RESET;
        pEnable1_ff <= bsx_pkg::REG8_RESET;
      end else begin
        if (wrAct && isReg(awAddr_ff, bsx_pkg::INTCTRL_ADDR) && wStrb_ff[0]) begin
          intCtrl_ff <= (wData_ff[7:0] & bsx_pkg::INTCTRL_IMP) | {6'h00, extRise, 1'b0};
        end else begin
          intCtrl_ff[bsx_pkg::INTF_POS] <= intCtrl_ff[bsx_pkg::INTF_POS] | extRise;
          if (wakeCond && intCtrl_ff[bsx_pkg::GLBEN_POS]) begin
            intCtrl_ff[bsx_pkg::GLBEN_POS] <= 1'b0;
          end
        end
        // RL12 comparator change flag
        if (wrAct && isReg(awAddr_ff, bsx_pkg::PFLAG1_ADDR) && wStrb_ff[0]) begin
          pFlag1_ff <= (wData_ff[7:0] | {1'b0, cmpChange, 6'h00}) & bsx_pkg::PFLAG1_IMP;
        end else if (cmpChange) begin
          pFlag1_ff[bsx_pkg::CMPF_POS] <= 1'b1;
        end
        if (wrAct && isReg(awAddr_ff, bsx_pkg::PENABLE1_ADDR) && wStrb_ff[0]) begin
          pEnable1_ff <= wData_ff[7:0] & bsx_pkg::PFLAG1_IMP;
        end
      end
      if (wrAct && isReg(awAddr_ff, bsx_pkg::FADDR_ADDR) && wStrb_ff[0]) begin
        fileAddr_ff <= wData_ff[6:0];
      end
    end
  end

  // RL13 brown-out clears bit 0
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pwrCtrl_ff <= bsx_pkg::REG8_RESET;
    end else if (ce) begin
      if (borRise) begin
        pwrCtrl_ff[bsx_pkg::BOR_POS] <= 1'b0;
      end else if (wrAct && isReg(awAddr_ff, bsx_pkg::PWRCTRL_ADDR) && wStrb_ff[0]) begin
        pwrCtrl_ff <= wData_ff[7:0] & bsx_pkg::PWRCTRL_IMP;
      end
    end
  end

  // ============================================================
  // Interrupt status, mask and output
  always_comb begin
    nxt_irqStat = irqStat_ff;
    if (wrAct && isReg(awAddr_ff, bsx_pkg::IRQSTAT_ADDR)) begin
      nxt_irqStat = irqStat_ff & ~wMerged[4:0];
    end
    nxt_irqStat[bsx_pkg::EV_SKIP]    = nxt_irqStat[bsx_pkg::EV_SKIP] | (execGo & skip);
    nxt_irqStat[bsx_pkg::EV_WAKE]    = nxt_irqStat[bsx_pkg::EV_WAKE] | (wakeCond & ~softReset);
    nxt_irqStat[bsx_pkg::EV_BOR]     = nxt_irqStat[bsx_pkg::EV_BOR] | borRise;
    nxt_irqStat[bsx_pkg::EV_ILLEGAL] = nxt_irqStat[bsx_pkg::EV_ILLEGAL] | (execGo & ~legal);
    nxt_irqStat[bsx_pkg::EV_DISCARD] = nxt_irqStat[bsx_pkg::EV_DISCARD] | discard;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqStat_ff <= 5'h00;
      irqMask_ff <= 5'h00;
      irq        <= 1'b0;
    end else if (ce) begin
      irqStat_ff <= nxt_irqStat;
      if (wrAct && isReg(awAddr_ff, bsx_pkg::IRQMASK_ADDR) && wStrb_ff[0]) begin
        irqMask_ff <= wData_ff[4:0];
      end
      irq <= |(nxt_irqStat & irqMask_ff);
    end
  end

  // ============================================================
  // AXI4-Lite write channels
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awHave_ff     <= 1'b0;
      awAddr_ff     <= 8'h00;
      s_axi_awready <= 1'b1;
      wHave_ff      <= 1'b0;
      wData_ff      <= 32'h00000000;
      wStrb_ff      <= 4'h0;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= bsx_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_ff     <= 1'b1;
        awAddr_ff     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (wrAct) begin
        awHave_ff     <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_ff     <= 1'b1;
        wData_ff     <= s_axi_wdata;
        wStrb_ff     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (wrAct) begin
        wHave_ff     <= 1'b0;
        s_axi_wready <= 1'b1;
      end
      if (wrAct) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_ff[7:2] <= bsx_pkg::ICOUNT_ADDR[7:2]) ? bsx_pkg::RESP_OKAY : bsx_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ============================================================
  // AXI4-Lite read channel
  // RL14 unimplemented bits read zero
  always_comb begin
    readHit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      bsx_pkg::INSTR_ADDR:    readVal = {18'h00000, lastInstr_ff};
      bsx_pkg::WORK_ADDR:     readVal = {24'h000000, work_ff};
      bsx_pkg::STATE_ADDR:    readVal = {27'h0000000, skipPend_ff, sleeping_ff, zFlag_ff, 2'b00};
      bsx_pkg::PC_ADDR:       readVal = {19'h00000, pc_ff};
      bsx_pkg::FADDR_ADDR:    readVal = {25'h0000000, fileAddr_ff};
      bsx_pkg::FDATA_ADDR:    readVal = {24'h000000, fileMem[fileAddr_ff]};
      bsx_pkg::INTCTRL_ADDR:  readVal = {24'h000000, intCtrl_ff};
      bsx_pkg::PFLAG1_ADDR:   readVal = {24'h000000, pFlag1_ff};
      bsx_pkg::PENABLE1_ADDR: readVal = {24'h000000, pEnable1_ff};
      bsx_pkg::PWRCTRL_ADDR:  readVal = {24'h000000, pwrCtrl_ff};
      bsx_pkg::CTRL_ADDR:     readVal = 32'h00000000;
      bsx_pkg::IRQSTAT_ADDR:  readVal = {27'h0000000, irqStat_ff};
      bsx_pkg::IRQMASK_ADDR:  readVal = {27'h0000000, irqMask_ff};
      bsx_pkg::ICOUNT_ADDR:   readVal = {16'h0000, instrCount_ff};
      default: begin
        readVal = 32'h00000000;
        readHit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= bsx_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= readVal;
        s_axi_rresp   <= readHit ? bsx_pkg::RESP_OKAY : bsx_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

// ---- verilog/bsx_pkg.sv ----
// ============================================================
// Shared constants of the bit and skip executor
package bsx_pkg;

  // ============================================================
  // Register byte offsets
  localparam logic [7:0] INSTR_ADDR    = 8'h00;
  localparam logic [7:0] WORK_ADDR     = 8'h04;
  localparam logic [7:0] STATE_ADDR    = 8'h08;
  localparam logic [7:0] PC_ADDR       = 8'h0C;
  localparam logic [7:0] FADDR_ADDR    = 8'h10;
  localparam logic [7:0] FDATA_ADDR    = 8'h14;
  localparam logic [7:0] INTCTRL_ADDR  = 8'h18;
  localparam logic [7:0] PFLAG1_ADDR   = 8'h1C;
  localparam logic [7:0] PENABLE1_ADDR = 8'h20;
  localparam logic [7:0] PWRCTRL_ADDR  = 8'h24;
  localparam logic [7:0] CTRL_ADDR     = 8'h28;
  localparam logic [7:0] IRQSTAT_ADDR  = 8'h2C;
  localparam logic [7:0] IRQMASK_ADDR  = 8'h30;
  localparam logic [7:0] ICOUNT_ADDR   = 8'h34;

  // ============================================================
  // Instruction word fields
  localparam int          INSTR_W    = 14;
  localparam logic [1:0]  CLS_BYTE   = 2'h0;
  localparam logic [1:0]  CLS_BIT    = 2'h1;
  localparam logic [1:0]  OP_BCLR    = 2'h0;
  localparam logic [1:0]  OP_BSET    = 2'h1;
  localparam logic [1:0]  OP_BTSC    = 2'h2;
  localparam logic [3:0]  OP_INCSZ   = 4'hF;
  localparam logic [3:0]  OP_IORF    = 4'h4;
  localparam logic [13:0] NOP_WORD   = 14'h0000;
  localparam int          CLS_HI     = 13;
  localparam int          CLS_LO     = 12;
  localparam int          DEST_BIT   = 7;
  localparam int          BIDX_HI    = 9;
  localparam int          BIDX_LO    = 7;

  // ============================================================
  // Special register layout, reset values and vectors
  localparam logic [12:0] PC_RESET    = 13'h0000;
  localparam logic [12:0] INT_VECTOR  = 13'h0004;
  localparam logic [7:0]  INTCTRL_IMP = 8'hD2;
  localparam logic [7:0]  PFLAG1_IMP  = 8'h40;
  localparam logic [7:0]  PWRCTRL_IMP = 8'h03;
  localparam logic [7:0]  REG8_RESET  = 8'h00;
  localparam int          GLBEN_POS   = 7;
  localparam int          PEIE_POS    = 6;
  localparam int          INTE_POS    = 4;
  localparam int          INTF_POS    = 1;
  localparam int          CMPF_POS    = 6;
  localparam int          BOR_POS     = 0;
  localparam int          Z_POS       = 2;

  // ============================================================
  // Interrupt events
  localparam int EV_W       = 5;
  localparam int EV_SKIP    = 0;
  localparam int EV_WAKE    = 1;
  localparam int EV_BOR     = 2;
  localparam int EV_ILLEGAL = 3;
  localparam int EV_DISCARD = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- verilog/bsx_pin_sync.sv ----
`timescale 1ns/100ps
// ============================================================
// Three-stage pin synchroniser; output takes stage 3 when stages 2 and 3 agree and clears to zero when they differ
module bsx_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Pins and result
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] stableOut
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
      stage3_ff <= '0;
    end else if (ce) begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // Per bit: accept stage 3 when the last two stages agree, clear to zero when they differ
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stableOut <= '0;
    end else if (ce) begin
      stableOut <= (stableOut & ~(stage2_ff ^ stage3_ff)) | (stage3_ff & ~(stage2_ff ^ stage3_ff));
    end
  end

endmodule

// ---- verilog/bsx_exec_unit.sv ----
`timescale 1ns/100ps
// ============================================================
// Combinational decode and result of one instruction word
module bsx_exec_unit (
  // Operands
  input  wire logic [13:0] instrWord,
  input  wire logic [7:0]  fileVal,
  input  wire logic [7:0]  workVal,
  // Results
  output logic             legal,
  output logic [7:0]       result,
  output logic             wrWork,
  output logic             wrFile,
  output logic             skip,
  output logic             zUpdate,
  output logic             zValue
);

  logic [1:0] cls;
  logic [7:0] bitMask;
  logic       toFile;

  always_comb begin
    // RL16 class first
    cls     = instrWord[bsx_pkg::CLS_HI:bsx_pkg::CLS_LO];
    // RL5 bit index field
    bitMask = 8'h01 << instrWord[bsx_pkg::BIDX_HI:bsx_pkg::BIDX_LO];
    toFile  = instrWord[bsx_pkg::DEST_BIT];
    legal   = 1'b0;
    result  = fileVal;
    wrWork  = 1'b0;
    wrFile  = 1'b0;
    skip    = 1'b0;
    zUpdate = 1'b0;
    zValue  = 1'b0;
    if (instrWord == bsx_pkg::NOP_WORD) begin
      legal = 1'b1;
    end else if (cls == bsx_pkg::CLS_BIT) begin
      case (instrWord[11:10])
        // RL1 clear one bit
        bsx_pkg::OP_BCLR: begin
          legal  = 1'b1;
          result = fileVal & ~bitMask;
          wrFile = 1'b1;
        end
        // RL2 set one bit
        bsx_pkg::OP_BSET: begin
          legal  = 1'b1;
          result = fileVal | bitMask;
          wrFile = 1'b1;
        end
        // RL3 skip on clear bit
        bsx_pkg::OP_BTSC: begin
          legal = 1'b1;
          skip  = ((fileVal & bitMask) == 8'h00);
        end
        default: begin
          legal = 1'b0;
        end
      endcase
    end else if (cls == bsx_pkg::CLS_BYTE) begin
      case (instrWord[11:8])
        // RL6 increment, flags kept
        bsx_pkg::OP_INCSZ: begin
          legal  = 1'b1;
          result = fileVal + 8'h01;
          // RL7 destination select
          wrFile = toFile;
          wrWork = ~toFile;
          // RL8 skip on zero
          skip   = (result == 8'h00);
        end
        // RL9 inclusive OR, zero flag
        bsx_pkg::OP_IORF: begin
          legal   = 1'b1;
          result  = fileVal | workVal;
          wrFile  = toFile;
          wrWork  = ~toFile;
          zUpdate = 1'b1;
          zValue  = (result == 8'h00);
        end
        default: begin
          legal = 1'b0;
        end
      endcase
    end
  end

endmodule

// ---- tb/bsx_core_assertions.sv ----
`timescale 1ns/100ps
// ============================================================
// Bus handshake checks seen at the top ports
module bsx_core_assertions (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // Bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready ##1 s_axi_bvalid) else $error("write answer late");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not released");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  chk_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == bsx_pkg::RESP_SLVERR |-> s_axi_rdata == 0)
    else $error("error read carries data");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == bsx_pkg::RESP_SLVERR);
  cover property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready);
endmodule

// ---- tb/bsx_core_tb.sv ----
`timescale 1ns/100ps
module bsx_core_tb;
  logic        sys_clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic        extIntPin = 1'b0, cmpOutPin = 1'b0, masterResetPin = 1'b0, brownOutPin = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdVal;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, sleeping_ff;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          nFail = 0, compares = 0, n;
  always #4 sys_clk = ~sys_clk;
  bsx_core dut (.sys_clk, .rst, .ce, .extIntPin, .cmpOutPin, .masterResetPin, .brownOutPin,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .sleeping_ff);
  task automatic results();
    $display("%0d compares, %0d mismatches", compares, nFail);
    if (nFail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bounded waits end the run as a failure
  task automatic tmo(input int k);
    if (k >= 60) begin
      nFail++;
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && k < 60);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(k);
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 60);
    rdVal = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(k);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), rdVal, e);
  endtask
  task automatic setf(input logic [7:0] a, input logic [7:0] d);
    wr(8'h10, {24'h0, a});
    wr(8'h14, {24'h0, d});
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(8'h0C, 32'h0);
    rdc(8'h24, 32'h0);
    rd(8'h38);
    chk("unmapped resp", {30'h0, rsp}, {30'h0, bsx_pkg::RESP_SLVERR});
    wr(8'h38, 32'h1);
    chk("unmapped wr resp", {30'h0, rsp}, {30'h0, bsx_pkg::RESP_SLVERR});
    wr(8'h18, 32'hFF);
    chk("wr resp", {30'h0, rsp}, {30'h0, bsx_pkg::RESP_OKAY});
    rdc(8'h18, 32'hD2);
    wr(8'h18, 32'h0);
    $display("test reset done");
    setf(8'h05, 8'hC7);
    wr(8'h00, 32'h1385);
    rdc(8'h14, 32'h47);
    wr(8'h00, 32'h1785);
    rdc(8'h14, 32'hC7);
    setf(8'h7F, 8'h00);
    wr(8'h00, 32'h147F);
    rdc(8'h14, 32'h01);
    rdc(8'h0C, 32'h3);
    wr(8'h10, 32'h05);
    wr(8'h00, 32'h1885);
    wr(8'h00, 32'h1005);
    rdc(8'h14, 32'hC6);
    wr(8'h00, 32'h1985);
    wr(8'h00, 32'h1585);
    rdc(8'h14, 32'hC6);
    rdc(8'h0C, 32'h7);
    rdc(8'h2C, 32'h11);
    chk("irq masked", irq, 1'b0);
    wr(8'h30, 32'h1);
    rd(8'h2C);
    chk("irq raised", irq, 1'b1);
    wr(8'h2C, 32'h11);
    rdc(8'h2C, 32'h0);
    chk("irq cleared", irq, 1'b0);
    $display("test bit ops done");
    wr(8'h04, 32'h91);
    wr(8'h14, 32'h13);
    wr(8'h00, 32'h0405);
    rdc(8'h04, 32'h93);
    wr(8'h00, 32'h0485);
    rdc(8'h14, 32'h93);
    rdc(8'h08, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h14, 32'h0);
    wr(8'h00, 32'h0405);
    rdc(8'h08, 32'h4);
    wr(8'h14, 32'hFF);
    wr(8'h00, 32'h0F85);
    rdc(8'h14, 32'h0);
    rdc(8'h2C, 32'h1);
    wr(8'h00, 32'h1405);
    rdc(8'h14, 32'h0);
    rdc(8'h08, 32'h4);
    wr(8'h00, 32'h0F05);
    rdc(8'h04, 32'h1);
    rdc(8'h14, 32'h0);
    $display("test byte ops done");
    wr(8'h18, 32'h90);
    wr(8'h28, 32'h1);
    rdc(8'h08, 32'hC);
    extIntPin <= 1'b1;
    for (n = 0; n < 60 && sleeping_ff !== 1'b0; n++) @(posedge sys_clk);
    tmo(n);
    rdc(8'h0C, 32'h4);
    rdc(8'h18, 32'h12);
    rdc(8'h2C, 32'h13);
    rdc(8'h1C, 32'h0);
    cmpOutPin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rdc(8'h1C, 32'h40);
    $display("test wake done");
    wr(8'h24, 32'h3);
    masterResetPin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    masterResetPin <= 1'b0;
    rdc(8'h24, 32'h3);
    rdc(8'h0C, 32'h0);
    brownOutPin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    brownOutPin <= 1'b0;
    rdc(8'h24, 32'h2);
    rdc(8'h2C, 32'h17);
    wr(8'h00, 32'h3000);
    rdc(8'h2C, 32'h1F);
    // Frozen clock enable must hold back the comparator change
    ce        <= 1'b0;
    cmpOutPin <= 1'b0;
    repeat (8) @(posedge sys_clk);
    ce <= 1'b1;
    rdc(8'h1C, 32'h0);
    repeat (8) @(posedge sys_clk);
    rdc(8'h1C, 32'h40);
    $display("test resets done");
    results();
  end
endmodule
bind bsx_core bsx_core_assertions chk (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
